// ---- logic/slr_pkg.sv ----
/*
  Shared constants and types for the set-reset latch unit: register
  offsets, field positions, reset values and the width of the bus.
  Assumes an 8-bit register bus with a small word address.
*/
`default_nettype none

package slr_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ---------------------------------------------------------------
  // Register offsets (word addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0; // latch_control_a
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1; // latch_control_b
  localparam logic [ADDR_W-1:0] OFS_CTRL_C = 4'h2; // comparator sync
  localparam logic [ADDR_W-1:0] OFS_STATE  = 4'h3; // latch state

  // ---------------------------------------------------------------
  // latch_control_a fields
  // ---------------------------------------------------------------
  localparam int unsigned A_SOFT_CLR  = 0; // soft_clear_strobe
  localparam int unsigned A_SOFT_SET  = 1; // soft_set_strobe
  localparam int unsigned A_QN_EN     = 2; // inverted_output_enable
  localparam int unsigned A_Q_EN      = 3; // true_output_enable
  localparam int unsigned A_PERIOD_LO = 4; // latch_period_select 6:4
  localparam int unsigned PERIOD_W    = 3;

  // ---------------------------------------------------------------
  // latch_control_b fields: low nibble clears, high nibble sets.
  // Inside each nibble: 0 comp two, 1 comp one, 2 pin, 3 periodic.
  // ---------------------------------------------------------------
  localparam int unsigned B_CLR_LO  = 0;
  localparam int unsigned B_SET_LO  = 4;
  localparam int unsigned SRC_W     = 4;

  // ---------------------------------------------------------------
  // Comparator sync register fields
  // ---------------------------------------------------------------
  localparam int unsigned C_SYNC_ONE = 0;
  localparam int unsigned C_SYNC_TWO = 1;

  // ---------------------------------------------------------------
  // Values after reset and counts
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_CTRL_A = 8'h00;
  localparam logic [DATA_W-1:0] RST_CTRL_B = 8'h00;
  localparam logic [1:0]        RST_CTRL_C = 2'h0;
  localparam int unsigned       SYNC_STAGES = 2;
  localparam int unsigned       DIV_W       = 8;

  typedef logic [SRC_W-1:0] slr_src_t;

endpackage : slr_pkg

`default_nettype wire

// ---- logic/slr_pulse_gen.sv ----
/*
  Periodic pulse source for the latch. Emits one-cycle pulses, one
  per selected period of 2**(code+1) system clock cycles.
  Assumes a synchronous active-low reset on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_pulse_gen
  import slr_pkg::*;
(
  input  wire logic                         clk_i,   // System clock
  input  wire logic                         rst_n_i, // Sync reset, low
  input  wire logic [slr_pkg::PERIOD_W-1:0] sel_i,   // Period code
  output logic                              pulse_o  // One-cycle tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             pulse;
  } slr_gen_t;

  slr_gen_t s_q;
  slr_gen_t s_d;

  // Terminal count for a period code; period is 2**(code+1) cycles.
  function automatic logic [DIV_W-1:0] last_count(
    input logic [PERIOD_W-1:0] code
  );
    logic [DIV_W-1:0] one;
    one = {{(DIV_W-1){1'b0}}, 1'b1};
    // Widen the shift count so that code 7 gives eight, not zero.
    last_count = (one << ({1'b0, code} + 4'h1)) - one;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (s_q.cnt >= last_count(sel_i)) begin
      s_d.cnt   = '0;
      s_d.pulse = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
    if (!rst_n_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign pulse_o = s_q.pulse;

endmodule // slr_pulse_gen

`default_nettype wire

// ---- logic/slr_latch_top.sv ----
/*
  Set-reset latch unit: one reset-dominant latch fed by software
  strobes, two comparators, an external pin and a periodic source,
  with separately enabled true and inverted pin drivers.
  Assumes comparator, pin and timer clock inputs are asynchronous
  and that the port logic supplies the pin direction bits.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_latch_top
  import slr_pkg::*;
(
  input  wire logic                       SYS_CLK_I,     // 20 MHz clock
  input  wire logic                       RESETN_I,      // Sync reset
  input  wire logic [slr_pkg::ADDR_W-1:0] ADDR_I,        // Reg address
  input  wire logic [slr_pkg::DATA_W-1:0] WR_DATA_I,     // Write data
  input  wire logic                       WR_STB_I,      // Write strobe
  input  wire logic                       RD_STB_I,      // Read strobe
  output logic      [slr_pkg::DATA_W-1:0] RD_DATA_O,     // Read data
  input  wire logic                       CMP_ONE_I,     // Comparator 1
  input  wire logic                       CMP_TWO_I,     // Comparator 2
  input  wire logic                       EXT_LATCH_I,   // Latch pin
  input  wire logic                       TMR_CLK_I,     // Timer clock
  input  wire logic                       DIR_Q_I,       // Q pin dir
  input  wire logic                       DIR_QN_I,      // QN pin dir
  output logic                            Q_PIN_O,       // Q pin level
  output logic                            Q_PIN_OE_N_O,  // Q drive, low
  output logic                            QN_PIN_O,      // QN level
  output logic                            QN_PIN_OE_N_O  // QN drive, low
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PERIOD_W-1:0]    period;
    logic                   q_en;
    logic                   qn_en;
    slr_src_t               set_en;
    slr_src_t               clr_en;
    logic [1:0]             sync_sel;
    logic                   soft_set;
    logic                   soft_clr;
    logic [SYNC_STAGES-1:0] cmp_one_s;
    logic [SYNC_STAGES-1:0] cmp_two_s;
    logic [SYNC_STAGES-1:0] ext_s;
    logic [SYNC_STAGES-1:0] tmr_s;
    logic                   tmr_prev;
    logic                   cmp_one_t;
    logic                   cmp_two_t;
    logic                   latch;
    logic [DATA_W-1:0]      rd_data;
    logic                   q_pin;
    logic                   q_oe_n;
    logic                   qn_pin;
    logic                   qn_oe_n;
  } slr_state_t;

  slr_state_t st_q;
  slr_state_t st_d;
  logic       tick;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Any enabled source that is high asserts the input.
  function automatic logic any_source(
    input slr_src_t en,
    input slr_src_t src
  );
    any_source = |(en & src);
  endfunction

  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Periodic source
  // ---------------------------------------------------------------
  slr_pulse_gen u_pulse (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .sel_i   (st_q.period),
    .pulse_o (tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic     cmp_one;
    logic     cmp_two;
    logic     tmr_rise;
    slr_src_t srcs;
    logic     set_in;
    logic     clr_in;
    cmp_one  = 1'b0;
    cmp_two  = 1'b0;
    tmr_rise = 1'b0;
    srcs     = '0;
    set_in   = 1'b0;
    clr_in   = 1'b0;

    st_d = st_q;

    // Pin-side inputs go through two flops before anything looks.
    st_d.cmp_one_s = {st_q.cmp_one_s[0], CMP_ONE_I};
    st_d.cmp_two_s = {st_q.cmp_two_s[0], CMP_TWO_I};
    st_d.ext_s     = {st_q.ext_s[0], EXT_LATCH_I};
    st_d.tmr_s     = {st_q.tmr_s[0], TMR_CLK_I};
    st_d.tmr_prev  = st_q.tmr_s[1];

    // Comparators optionally resampled on the timer clock edge.
    tmr_rise = st_q.tmr_s[1] & ~st_q.tmr_prev;
    if (tmr_rise) begin
      st_d.cmp_one_t = st_q.cmp_one_s[1];
      st_d.cmp_two_t = st_q.cmp_two_s[1];
    end
    cmp_one = st_q.sync_sel[C_SYNC_ONE] ? st_q.cmp_one_t
                                        : st_q.cmp_one_s[1];
    cmp_two = st_q.sync_sel[C_SYNC_TWO] ? st_q.cmp_two_t
                                        : st_q.cmp_two_s[1];

    // Source vector: 0 comp two, 1 comp one, 2 pin, 3 periodic.
    srcs = {tick, st_q.ext_s[1], cmp_one, cmp_two};

    // Periodic enables sit at bit 3 of each nibble.
    set_in = any_source(st_q.set_en, srcs) | st_q.soft_set;
    clr_in = any_source(st_q.clr_en, srcs) | st_q.soft_clr;

    // Reset-dominant update, no enable or gating on the state.
    st_d.latch = (st_q.latch | set_in) & ~clr_in;

    // Software strobes live for one cycle only.
    st_d.soft_set = 1'b0;
    st_d.soft_clr = 1'b0;

    // Register writes.
    if (WR_STB_I) begin
      if (reg_hit(ADDR_I, OFS_CTRL_A)) begin
        st_d.soft_clr = WR_DATA_I[A_SOFT_CLR];
        st_d.soft_set = WR_DATA_I[A_SOFT_SET];
        st_d.qn_en    = WR_DATA_I[A_QN_EN];
        st_d.q_en     = WR_DATA_I[A_Q_EN];
        st_d.period   = WR_DATA_I[A_PERIOD_LO +: PERIOD_W];
      end
      if (reg_hit(ADDR_I, OFS_CTRL_B)) begin
        st_d.clr_en = WR_DATA_I[B_CLR_LO +: SRC_W];
        st_d.set_en = WR_DATA_I[B_SET_LO +: SRC_W];
      end
      if (reg_hit(ADDR_I, OFS_CTRL_C)) begin
        st_d.sync_sel = WR_DATA_I[1:0];
      end
    end

    // Register reads: data stand only in the cycle after the strobe.
    st_d.rd_data = '0;
    if (RD_STB_I) begin
      case (ADDR_I)
        OFS_CTRL_A: begin
          // Strobe bits always read back as zero.
          st_d.rd_data = {1'b0, st_q.period, st_q.q_en,
                          st_q.qn_en, 2'b00};
        end
        OFS_CTRL_B: begin
          st_d.rd_data = {st_q.set_en, st_q.clr_en};
        end
        OFS_CTRL_C: begin
          st_d.rd_data = {6'h00, st_q.sync_sel};
        end
        OFS_STATE: begin
          st_d.rd_data = {6'h00, ~st_q.latch, st_q.latch};
        end
        default: begin
          st_d.rd_data = '0;
        end
      endcase
    end

    // Pin drivers: each output has its own enable and both may be
    // on together; the port's direction bit must also be cleared.
    st_d.q_pin   = st_q.latch;
    st_d.qn_pin  = ~st_q.latch;
    st_d.q_oe_n  = ~(st_q.q_en & ~DIR_Q_I);
    st_d.qn_oe_n = ~(st_q.qn_en & ~DIR_QN_I);

    // Reset leaves the latch itself untouched, so its value after
    // reset is whatever it held; software must define it first.
    if (!RESETN_I) begin
      st_d.period    = RST_CTRL_A[A_PERIOD_LO +: PERIOD_W];
      st_d.q_en      = RST_CTRL_A[A_Q_EN];
      st_d.qn_en     = RST_CTRL_A[A_QN_EN];
      st_d.set_en    = RST_CTRL_B[B_SET_LO +: SRC_W];
      st_d.clr_en    = RST_CTRL_B[B_CLR_LO +: SRC_W];
      st_d.sync_sel  = RST_CTRL_C;
      st_d.soft_set  = 1'b0;
      st_d.soft_clr  = 1'b0;
      st_d.cmp_one_s = '0;
      st_d.cmp_two_s = '0;
      st_d.ext_s     = '0;
      st_d.tmr_s     = '0;
      st_d.tmr_prev  = 1'b0;
      st_d.cmp_one_t = 1'b0;
      st_d.cmp_two_t = 1'b0;
      st_d.rd_data   = '0;
      st_d.q_pin     = 1'b0;
      st_d.qn_pin    = 1'b0;
      st_d.q_oe_n    = 1'b1;
      st_d.qn_oe_n   = 1'b1;
      st_d.latch     = st_q.latch;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RD_DATA_O     = st_q.rd_data;
  assign Q_PIN_O       = st_q.q_pin;
  assign Q_PIN_OE_N_O  = st_q.q_oe_n;
  assign QN_PIN_O      = st_q.qn_pin;
  assign QN_PIN_OE_N_O = st_q.qn_oe_n;

endmodule // slr_latch_top

`default_nettype wire

// ---- testbench/slr_latch_props.sv ----
/*
  Checker for the latch unit, watching only the top-level ports.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_latch_props
  import slr_pkg::*;
(
  input  wire logic                       SYS_CLK_I,     // Clock
  input  wire logic                       RESETN_I,      // Reset, low
  input  wire logic [slr_pkg::ADDR_W-1:0] ADDR_I,        // Address
  input  wire logic [slr_pkg::DATA_W-1:0] WR_DATA_I,     // Write data
  input  wire logic                       WR_STB_I,      // Write strobe
  input  wire logic                       RD_STB_I,      // Read strobe
  input  wire logic [slr_pkg::DATA_W-1:0] RD_DATA_O,     // Read data
  input  wire logic                       DIR_Q_I,       // Q pin dir
  input  wire logic                       DIR_QN_I,      // QN pin dir
  input  wire logic                       Q_PIN_O,       // Q level
  input  wire logic                       Q_PIN_OE_N_O,  // Q drive
  input  wire logic                       QN_PIN_O,      // QN level
  input  wire logic                       QN_PIN_OE_N_O  // QN drive
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  // Last written byte, so a read-back can be tied to its write.
  logic [7:0] wd_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (WR_STB_I) wd_q <= WR_DATA_I;
  end
  wire wa = WR_STB_I && ADDR_I == OFS_CTRL_A;
  wire wb = WR_STB_I && ADDR_I == OFS_CTRL_B;
  wire wc = WR_STB_I && ADDR_I == OFS_CTRL_C;
  wire ra = RD_STB_I && ADDR_I == OFS_CTRL_A;
  wire rb = RD_STB_I && ADDR_I == OFS_CTRL_B;
  wire rc = RD_STB_I && ADDR_I == OFS_CTRL_C;
  wire rs = RD_STB_I && ADDR_I == OFS_STATE;

  AST_CLR_WINS: assert property (wa && WR_DATA_I[A_SOFT_CLR] |->
    ##3 (!Q_PIN_O && QN_PIN_O)) else $error("soft clear lost");
  AST_SELF_CLR: assert property (ra |=> RD_DATA_O[1:0] == 2'h0)
    else $error("strobe bits read back set");
  AST_A_FIELDS: assert property (wa ##1 ra |=>
    RD_DATA_O == {1'b0, wd_q[6:2], 2'h0}) else $error("control a bad");
  AST_B_ENABLES: assert property (wb ##1 rb |=> RD_DATA_O == wd_q)
    else $error("control b bad");
  AST_SYNC_SEL: assert property (wc ##1 rc |=>
    RD_DATA_O == {6'h00, wd_q[1:0]}) else $error("sync select bad");
  AST_STATE_RD: assert property (rs |=>
    RD_DATA_O == {6'h00, QN_PIN_O, Q_PIN_O}) else $error("state bad");
  AST_Q_OE: assert property (DIR_Q_I |=> Q_PIN_OE_N_O)
    else $error("q drives while input");
  AST_QN_OE: assert property (DIR_QN_I |=> QN_PIN_OE_N_O)
    else $error("qn drives while input");
  AST_COMPL: assert property ($rose(Q_PIN_O) |-> !QN_PIN_O)
    else $error("outputs not complementary");

  COV_CLR: cover property (wa && WR_DATA_I[A_SOFT_CLR]);
  COV_BOTH: cover property (!Q_PIN_OE_N_O && !QN_PIN_OE_N_O);
  COV_STATE: cover property (rs ##1 RD_DATA_O[0]);
endmodule // slr_latch_props

bind slr_latch_top slr_latch_props props_u (.SYS_CLK_I, .RESETN_I,
  .ADDR_I, .WR_DATA_I, .WR_STB_I, .RD_STB_I, .RD_DATA_O, .DIR_Q_I,
  .DIR_QN_I, .Q_PIN_O, .Q_PIN_OE_N_O, .QN_PIN_O, .QN_PIN_OE_N_O);

`default_nettype wire

// ---- testbench/slr_far_model.sv ----
/*
  Far side of the latch unit: comparators, latch input pin, timer
  clock and two port pads with pull-ups.
  Assumes the bench changes its commands right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_far_model (
  input  wire logic       run_i,     // Timer clock runs
  input  wire logic [2:0] src_i,     // Pin, comp one, comp two
  input  wire logic [1:0] lvl_i,     // Pad levels from unit
  input  wire logic [1:0] oe_n_i,    // Pad drives, low
  output logic            cmp_one_o, // Comparator one
  output logic            cmp_two_o, // Comparator two
  output logic            ext_o,     // Latch input pin
  output logic            tmr_o,     // Timer clock
  output logic      [1:0] pad_o      // Resolved pads
);
  // Analog sources move off the clock grid, as real ones do.
  assign #13 {ext_o, cmp_one_o, cmp_two_o} = src_i;
  initial tmr_o = 1'b0;
  // The timer clock stands still while stopped.
  always begin
    #130;
    if (run_i) tmr_o = ~tmr_o;
  end
  // A released pad floats to its pull-up level.
  assign pad_o[0] = oe_n_i[0] ? 1'b1 : lvl_i[0];
  assign pad_o[1] = oe_n_i[1] ? 1'b1 : lvl_i[1];
endmodule // slr_far_model

`default_nettype wire

// ---- testbench/slr_latch_top_tb.sv ----
/*
  Self-checking bench for the latch unit: registers, software
  strobes, each source, timer sync, periodic codes and pin drive.
  Assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_latch_top_tb;
  import slr_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, dq = 1, dqn = 1, run = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, d;
  logic [2:0] src = '0;
  logic [1:0] pad;
  logic c1, c2, ext, tck, q, qoe, qn, qnoe, lt;
  logic [15:0] lfsr = 16'h001f;
  int err_total = 0, num_checks = 0, n;
  always #25 clk = ~clk;

  slr_latch_top dut_u (.SYS_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr),
    .WR_DATA_I(wdat), .WR_STB_I(wr), .RD_STB_I(rd), .RD_DATA_O(rdat),
    .CMP_ONE_I(c1), .CMP_TWO_I(c2), .EXT_LATCH_I(ext), .TMR_CLK_I(tck),
    .DIR_Q_I(dq), .DIR_QN_I(dqn), .Q_PIN_O(q), .Q_PIN_OE_N_O(qoe),
    .QN_PIN_O(qn), .QN_PIN_OE_N_O(qnoe));
  slr_far_model far_u (.run_i(run), .src_i(src), .lvl_i({qn, q}),
    .oe_n_i({qnoe, qoe}), .cmp_one_o(c1), .cmp_two_o(c2), .ext_o(ext),
    .tmr_o(tck), .pad_o(pad));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_a(input logic [7:0] v);
    return {1'b0, v[6:2], 2'h0};
  endfunction
  function automatic logic [7:0] exp_st(input logic l);
    return {6'h00, ~l, l};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Writes wait an edge first, so a write may follow a read at once.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e,
                       input string nm);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(nm, rdat, e);
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    rdchk(OFS_CTRL_A, 8'h00, "ctrl_a");
    rdchk(OFS_CTRL_B, 8'h00, "ctrl_b");
    rdchk(OFS_CTRL_C, 8'h00, "sync");
    rdchk(4'hf, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_step(lfsr);
      d = lfsr[7:0] & 8'h73;
      wr_reg(OFS_CTRL_A, d);
      rdchk(OFS_CTRL_A, exp_a(d), "ctrl_a");
      wr_reg(OFS_CTRL_B, d);
      rdchk(OFS_CTRL_B, d, "ctrl_b");
      wr_reg(OFS_CTRL_C, d);
      rdchk(OFS_CTRL_C, {6'h00, d[1:0]}, "sync");
    end
    wr_reg(OFS_CTRL_B, 8'h00);
    wr_reg(OFS_CTRL_C, 8'h00);
    $display("test registers done");
    // A strobe reaches the latch one cycle after its write edge, so
    // each state read after a strobe write waits one edge before it is issued.
    wr_reg(OFS_CTRL_A, 8'h01);
    @(posedge clk);
    rdchk(OFS_STATE, exp_st(0), "soft clear");
    wr_reg(OFS_CTRL_A, 8'h02);
    @(posedge clk);
    rdchk(OFS_STATE, exp_st(1), "soft set");
    wr_reg(OFS_STATE, 8'h00);
    rdchk(OFS_STATE, exp_st(1), "state held");
    wr_reg(OFS_CTRL_A, 8'h03);
    @(posedge clk);
    rdchk(OFS_STATE, exp_st(0), "soft both");
    $display("test software done");
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_CTRL_B, 8'h10 << i);
      src <= 3'h1 << i;
      repeat (8) @(posedge clk);
      rdchk(OFS_STATE, exp_st(1), "src set");
      wr_reg(OFS_CTRL_B, 8'h11 << i);
      repeat (8) @(posedge clk);
      rdchk(OFS_STATE, exp_st(0), "src both");
      src <= '0;
      repeat (6) @(posedge clk);
      wr_reg(OFS_CTRL_A, 8'h02);
      @(posedge clk);
      rdchk(OFS_STATE, exp_st(1), "src low");
      src <= 3'h1 << i;
      repeat (8) @(posedge clk);
      rdchk(OFS_STATE, exp_st(0), "src clr");
      src <= '0;
    end
    $display("test sources done");
    // Pass 0 resyncs comparator one, pass 1 comparator two.
    for (int i = 0; i < 2; i++) begin
      run <= 1;
      repeat (30) @(posedge clk);
      run <= 0;
      wr_reg(OFS_CTRL_C, 8'h01 << i);
      wr_reg(OFS_CTRL_B, 8'h20 >> i);
      wr_reg(OFS_CTRL_A, 8'h01);
      src <= 3'h2 >> i;
      repeat (12) @(posedge clk);
      rdchk(OFS_STATE, exp_st(0), "sync hold");
      run <= 1;
      repeat (30) @(posedge clk);
      rdchk(OFS_STATE, exp_st(1), "sync pass");
      run <= 0;
      src <= '0;
      @(posedge clk);
    end
    $display("test sync done");
    wr_reg(OFS_CTRL_B, 8'h80);
    for (int k = 0; k < 8; k++) begin
      wr_reg(OFS_CTRL_A, {1'b0, 3'(k), 4'h1});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("cleared", {7'h00, q}, 8'h00);
      n = 0;
      while (q !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
      chk("period", 8'(n <= (2 << k) + 2), 8'h01);
      if (n == 300) final_report();
      // The rise just seen fixes the tick phase, so a clear issued now
      // makes the next rise come a known number of cycles later.
      if (k >= 2) begin
        wr_reg(OFS_CTRL_A, {1'b0, 3'(k), 4'h1});
        repeat (2) @(posedge clk);
        @(negedge clk);
        n = 0;
        while (q !== 1'b1 && n < 300) begin
          @(negedge clk);
          n++;
        end
        chk("period exact", 8'(n), 8'((2 << k) - 4));
        if (n == 300) final_report();
      end
    end
    $display("test periodic done");
    wr_reg(OFS_CTRL_B, 8'h00);
    lt = 1'b1;
    for (int j = 0; j < 8; j++) begin
      lfsr = lfsr_step(lfsr);
      if (j == 7) lfsr[5:2] = 4'h3;
      if (lfsr[0]) lt = 1'b0;
      else if (lfsr[1]) lt = 1'b1;
      wr_reg(OFS_CTRL_A, {4'h0, lfsr[3:0]});
      dq <= lfsr[4];
      dqn <= lfsr[5];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("q oe", {7'h00, qoe}, {7'h00, !(lfsr[3] && !lfsr[4])});
      chk("qn oe", {7'h00, qnoe}, {7'h00, !(lfsr[2] && !lfsr[5])});
      chk("pads", {6'h00, pad}, {6'h00, (lfsr[2] && !lfsr[5]) ? ~lt : 1'b1,
          (lfsr[3] && !lfsr[4]) ? lt : 1'b1});
      @(posedge clk);
    end
    $display("test pins done");
    final_report();
  end
endmodule // slr_latch_top_tb

`default_nettype wire
